// file: common/lso_frame_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries one received serial frame from the receiver to the core.
interface lso_frame_if;
  logic [7:0] data; // Byte shifted in, first bit in bit 7.
  logic valid; // One-cycle pulse: a complete eight-bit frame ended.
  logic accept; // Level from the core: frames may be delivered.

  // Receiver side.
  modport rx (output data, output valid, input accept);
  // Core side.
  modport core (input data, input valid, output accept);
endinterface
`default_nettype wire

// file: common/lso_pkg.sv
// Shared constants of the serial low-side output controller.
package lso_pkg;

  // Core clock rate in MHz, used to turn times into cycle counts.
  localparam int unsigned CLK_MHZ = 200;

  // Power-on release delay in milliseconds, as set by the delay capacitor.
  localparam int unsigned POR_DELAY_MS = 6;
  // Release delay in core cycles.
  localparam int unsigned POR_DELAY_CYCLES = POR_DELAY_MS * 1000 * CLK_MHZ;

  // Low-supply deglitch interval in microseconds.
  localparam int unsigned DEGLITCH_US = 40;
  // Deglitch interval in core cycles.
  localparam int unsigned DEGLITCH_CYCLES = DEGLITCH_US * CLK_MHZ;

  // Zero-cross filter interval in microseconds.
  localparam int unsigned ZC_FILTER_US = 20;
  // Zero-cross filter interval in core cycles.
  localparam int unsigned ZC_FILTER_CYCLES = ZC_FILTER_US * CLK_MHZ;

  // Width of the supervisor counter; holds the release delay.
  localparam int unsigned SUP_CNT_W = 21;
  // Width of the zero-cross filter counter.
  localparam int unsigned ZC_CNT_W = 12;

  // Number of data bits in one serial frame.
  localparam logic [3:0] FRAME_BITS = 4'h8;
  // Saturation value of the serial bit counter.
  localparam logic [3:0] BIT_CNT_MAX = 4'hf;

  // Byte address of the control register.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  // Byte address of the status register.
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  // Control register: serial frames are accepted when this bit is set.
  localparam int unsigned CTRL_ACCEPT_BIT = 0;
  // Reset value of the control register.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Status register field positions.
  localparam int unsigned STAT_OUTREG_LSB = 0;
  localparam int unsigned STAT_RELEASED_BIT = 8;
  localparam int unsigned STAT_ZC_BIT = 9;
  localparam int unsigned STAT_SUPPLY_BIT = 10;
  localparam int unsigned STAT_ENABLE_BIT = 11;

  // Reset value of the output register: every sink off.
  localparam logic [7:0] OUTREG_RESET = 8'h00;

  // States of the reset supervisor.
  typedef enum logic [0:0] {
    SUP_HOLD = 1'b0,
    SUP_RUN = 1'b1
  } lso_sup_state_type;

endpackage

// file: hdl/lso_core.sv
`timescale 1ns/1ps
`default_nettype none
module lso_core
  import lso_pkg::*;
#(
  parameter int unsigned POR_DELAY = POR_DELAY_CYCLES, // Release delay in cycles.
  parameter int unsigned DEGLITCH = DEGLITCH_CYCLES // Low-supply deglitch in cycles.
) (
  input wire logic pclk, // Core clock, 200 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic sclk, // Serial clock from the host.
  input wire logic select_n, // Serial select, active low.
  input wire logic mosi, // Serial data from the host.
  input wire logic direct_drive_enable, // Parallel enable for output one.
  output logic direct_drive_pull_en, // Weak pull-down enable for that pin.
  input wire logic supply_good, // Regulator above its threshold.
  output logic reset_n_out, // Open-drain reset output level.
  output logic reset_n_oe, // High while the reset pin is driven low.
  input wire logic mains_sense_in, // Mains image input.
  output logic zero_cross_clock_out, // Filtered zero-cross clock.
  output logic [7:0] sink_outputs // Sink outputs, bit 0 is output one.
);

  // Frame carrier between the receiver and this core.
  lso_frame_if frame ();

  logic [31:0] ctrl; // Control register.
  logic [7:0] out_reg; // Output register, one bit per sink.
  logic [2:0] in_meta; // First synchroniser stage: enable, supply, mains.
  logic [2:0] in_sync; // Second synchroniser stage.
  lso_sup_state_type sup_state; // Reset supervisor state.
  lso_sup_state_type next_sup_state; // Next supervisor state.
  logic [SUP_CNT_W-1:0] sup_cnt; // Supervisor timer.
  logic [SUP_CNT_W-1:0] next_sup_cnt; // Next supervisor timer.
  logic [ZC_CNT_W-1:0] zc_cnt; // Zero-cross filter timer.

  // Timer limits at the counter widths.
  localparam logic [SUP_CNT_W-1:0] POR_LIMIT = SUP_CNT_W'(POR_DELAY - 1);
  localparam logic [SUP_CNT_W-1:0] DEG_LIMIT = SUP_CNT_W'(DEGLITCH - 1);
  localparam logic [ZC_CNT_W-1:0] ZC_LIMIT = ZC_CNT_W'(ZC_FILTER_CYCLES - 1);

  // Named synchronised inputs.
  wire enable_sync = in_sync[0];
  wire supply_sync = in_sync[1];
  wire mains_sync = in_sync[2];
  wire released = (sup_state == SUP_RUN);

  // Serial receiver instance.
  lso_spi_rx rx (
    .pclk(pclk),
    .presetn(presetn),
    .sclk(sclk),
    .select_n(select_n),
    .mosi(mosi),
    .frame(frame)
  );

  // Frames are taken only after release and while software allows them.
  assign frame.accept = released & ctrl[CTRL_ACCEPT_BIT];

  // Two flip-flops on each slow pin before any logic reads it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta <= 3'h0;
      in_sync <= 3'h0;
    end else begin
      in_meta <= {mains_sense_in, supply_good, direct_drive_enable};
      in_sync <= in_meta;
    end
  end

  // Supervisor: count the release delay while the supply is good, and count
  // the deglitch interval while it is low after release.
  always_comb begin
    next_sup_state = sup_state;
    next_sup_cnt = sup_cnt;
    unique case (sup_state)
      SUP_HOLD: begin
        if (!supply_sync) begin
          // Delay restarts whenever the supply dips.
          next_sup_cnt = '0;
        end else if (sup_cnt == POR_LIMIT) begin
          // Both conditions met, release the reset line.
          next_sup_state = SUP_RUN;
          next_sup_cnt = '0;
        end else begin
          next_sup_cnt = sup_cnt + 1'b1;
        end
      end
      SUP_RUN: begin
        if (supply_sync) begin
          // Short dips are forgiven.
          next_sup_cnt = '0;
        end else if (sup_cnt == DEG_LIMIT) begin
          // Low supply lasted the whole deglitch interval.
          next_sup_state = SUP_HOLD;
          next_sup_cnt = '0;
        end else begin
          next_sup_cnt = sup_cnt + 1'b1;
        end
      end
    endcase
  end

  // Supervisor registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_state <= SUP_HOLD;
      sup_cnt <= '0;
    end else begin
      sup_state <= next_sup_state;
      sup_cnt <= next_sup_cnt;
    end
  end

  // Reset pin: open drain, only ever pulled low, never driven high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_n_out <= 1'b0;
      reset_n_oe <= 1'b1;
    end else begin
      reset_n_out <= 1'b0;
      reset_n_oe <= ~released;
    end
  end

  // Output register: cleared at power-up and while reset is held,
  // loaded from each complete frame otherwise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= OUTREG_RESET;
    end else if (!released) begin
      out_reg <= OUTREG_RESET;
    end else if (frame.valid) begin
      out_reg <= frame.data;
    end
  end

  // Sink drive: off during reset, output one also follows the enable pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sink_outputs <= 8'h00;
    end else if (!released) begin
      sink_outputs <= 8'h00;
    end else begin
      sink_outputs <= {out_reg[7:1], out_reg[0] | enable_sync};
    end
  end

  // The pad pull-down keeps an open enable pin inactive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_drive_pull_en <= 1'b1;
    end else begin
      direct_drive_pull_en <= 1'b1;
    end
  end

  // Zero-cross filter: the output follows the mains input only after the
  // input has differed from it for the full filter interval.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_cnt <= '0;
      zero_cross_clock_out <= 1'b0;
    end else if (mains_sync == zero_cross_clock_out) begin
      zc_cnt <= '0;
    end else if (zc_cnt == ZC_LIMIT) begin
      zc_cnt <= '0;
      zero_cross_clock_out <= mains_sync;
    end else begin
      zc_cnt <= zc_cnt + 1'b1;
    end
  end

  // APB decode.
  wire apb_access = psel & penable & ~pready;
  wire hit_ctrl = (paddr == CTRL_ADDR);
  wire hit_status = (paddr == STATUS_ADDR);
  wire unmapped = ~(hit_ctrl | hit_status);
  wire apb_commit = psel & penable & pready & pwrite & hit_ctrl;

  // Status word showing the block's own state.
  wire [31:0] status_word = {20'h00000, enable_sync, supply_sync,
                             zero_cross_clock_out, released, out_reg};
  wire [31:0] read_word = hit_ctrl ? ctrl : (hit_status ? status_word : 32'h0);

  // APB answer: one wait state, then ready with data or error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & unmapped;
      if (apb_access && !pwrite) begin
        prdata <= read_word;
      end
    end
  end

  // Control register write takes effect at the completing edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (apb_commit) begin
      ctrl <= {31'h0000_0000, pwdata[CTRL_ACCEPT_BIT]};
    end
  end

endmodule
`default_nettype wire

// file: hdl/lso_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Serial receiver: samples the link pins on pclk and assembles frames.
module lso_spi_rx
  import lso_pkg::*;
(
  input wire logic pclk, // Core clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic sclk, // Serial clock pin.
  input wire logic select_n, // Frame select pin, active low.
  input wire logic mosi, // Serial data pin.
  lso_frame_if.rx frame // Frame towards the core.
);

  // Pin order in the synchroniser: 0 sclk, 1 select_n, 2 mosi.
  logic [2:0] pin_meta; // First synchroniser stage.
  logic [2:0] pin_sync; // Second stage, the only one logic reads.
  logic sclk_prev; // Serial clock one cycle ago.
  logic sel_prev; // Select one cycle ago.
  logic [7:0] shift; // Shift register for incoming bits.
  logic [3:0] bit_cnt; // Serial clocks seen in this frame, saturating.

  // Edge decode on the synchronised pins.
  wire sel_active = ~pin_sync[1];
  wire sclk_rise = pin_sync[0] & ~sclk_prev & sel_active;
  wire sel_rise = pin_sync[1] & ~sel_prev;
  wire frame_ok = (bit_cnt == FRAME_BITS) & frame.accept;

  // Two flip-flops on every pin before any decode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 3'h2;
      pin_sync <= 3'h2;
    end else begin
      pin_meta <= {mosi, select_n, sclk};
      pin_sync <= pin_meta;
    end
  end

  // Remember last levels for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev <= 1'b0;
      sel_prev <= 1'b1;
    end else begin
      sclk_prev <= pin_sync[0];
      sel_prev <= pin_sync[1];
    end
  end

  // Shift on rising serial clock while selected; close on select rising.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      frame.valid <= 1'b0;
      frame.data <= 8'h00;
    end else begin
      frame.valid <= 1'b0;
      if (sel_rise) begin
        // Only a frame of exactly eight clocks is delivered.
        frame.valid <= frame_ok;
        frame.data <= shift;
        bit_cnt <= 4'h0;
      end else if (!sel_active) begin
        // Clocks and data are ignored while deselected.
        bit_cnt <= 4'h0;
      end else if (sclk_rise) begin
        // Sample on the rising edge, first bit ends up in bit 7.
        shift <= {shift[6:0], pin_sync[2]};
        if (bit_cnt != BIT_CNT_MAX) begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: test/lso_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Ties the outputs of the controller to the inputs that may move them.
module lso_core_chk
  import lso_pkg::*;
#(
  parameter int unsigned POR_DELAY = POR_DELAY_CYCLES, // Release delay.
  parameter int unsigned DEGLITCH = DEGLITCH_CYCLES // Deglitch interval.
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic mosi,
  input wire logic direct_drive_enable,
  input wire logic direct_drive_pull_en,
  input wire logic supply_good,
  input wire logic reset_n_out,
  input wire logic reset_n_oe,
  input wire logic mains_sense_in,
  input wire logic zero_cross_clock_out,
  input wire logic [7:0] sink_outputs
);
  logic sup_q; // Supply level one cycle ago.
  logic zc_q; // Mains level one cycle ago.
  logic sel_q; // Select level one cycle ago.
  int unsigned sup_cnt; // Cycles the supply level has held.
  int unsigned zc_cnt; // Cycles the mains level has held.
  int unsigned sel_cnt; // Cycles since select last moved.
  // Counts how long supply, mains and select have each kept their level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_q <= 1'b0;
      zc_q <= 1'b0;
      sel_q <= 1'b1;
      sup_cnt <= 0;
      zc_cnt <= 0;
      sel_cnt <= 0;
    end else begin
      sup_q <= supply_good;
      zc_q <= mains_sense_in;
      sel_q <= select_n;
      sup_cnt <= (supply_good != sup_q) ? 0 : sup_cnt + 1;
      zc_cnt <= (mains_sense_in != zc_q) ? 0 : zc_cnt + 1;
      sel_cnt <= (select_n != sel_q) ? 0 : sel_cnt + 1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pull; direct_drive_pull_en; endproperty
  a_pull: assert property (p_pull) else $error("pull-down off");
  property p_sink_output_one; (direct_drive_enable && !reset_n_oe) [*5] |-> sink_outputs[0]; endproperty
  a_sink_output_one: assert property (p_sink_output_one) else $error("output one not on");
  property p_por; $fell(reset_n_oe) |-> supply_good && sup_cnt >= POR_DELAY; endproperty
  a_por: assert property (p_por) else $error("reset released early");
  property p_dgl; $rose(reset_n_oe) |-> !supply_good && sup_cnt >= DEGLITCH; endproperty
  a_dgl: assert property (p_dgl) else $error("reset asserted early");
  property p_off; reset_n_oe [*3] |-> sink_outputs == OUTREG_RESET; endproperty
  a_off: assert property (p_off) else $error("sink on in reset");
  property p_hold;
    $changed(sink_outputs[7:1]) |-> sel_cnt <= 12 || reset_n_oe || $past(reset_n_oe) ||
      $past(reset_n_oe, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("sink moved without frame");
  property p_zc; $changed(zero_cross_clock_out) |-> zc_cnt >= ZC_FILTER_CYCLES; endproperty
  a_zc: assert property (p_zc) else $error("zero-cross unfiltered");
  property p_rdy; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready timing");
endmodule
bind lso_core lso_core_chk #(.POR_DELAY(POR_DELAY), .DEGLITCH(DEGLITCH)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .sclk, .select_n, .mosi, .direct_drive_enable, .direct_drive_pull_en, .supply_good,
  .reset_n_out, .reset_n_oe, .mains_sense_in, .zero_cross_clock_out, .sink_outputs
);
`default_nettype wire

// file: test/lso_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial link: frames go out at a 160 ns serial clock.
module lso_host (
  input wire logic pclk, // Bench clock that paces every link edge.
  output logic sclk, // Serial clock, low between frames.
  output logic select_n, // Frame select, active low.
  output logic mosi // Serial data, most significant bit first.
);
  // The clock idles low while the frame select is high.
  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    mosi = 1'b0;
  end
  // Sends n clocks of byte b; 32 bench cycles per serial clock give 160 ns.
  // Data changes in the low phase, well clear of the rising serial edge.
  task automatic send(input logic [7:0] b, input int n);
    @(posedge pclk);
    select_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge pclk);
      mosi <= b[7 - (i % 8)];
      repeat (8) @(posedge pclk);
      sclk <= 1'b1;
      repeat (16) @(posedge pclk);
      sclk <= 1'b0;
    end
    repeat (16) @(posedge pclk);
    select_n <= 1'b1;
    mosi <= ~mosi;
    repeat (40) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// file: test/serial_low_side_output_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the controller over APB and the serial link and compares its pins.
module serial_low_side_output_control_tb_top
  import lso_pkg::*;
;
  localparam int PD = 50; // Shortened release delay in cycles.
  localparam int DG = 20; // Shortened deglitch in cycles.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic supply_good = 1'b1;
  logic mains_sense_in = 1'b0;
  logic direct_drive_enable = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, direct_drive_pull_en, reset_n_out, reset_n_oe;
  logic zero_cross_clock_out, sclk, select_n, mosi;
  logic [7:0] sink_outputs;
  logic [31:0] rdata; // Read data of the last transfer.
  logic rerr; // Error flag of the last transfer.
  int errors = 0;
  int cmp_count = 0;
  logic [7:0] pat [4] = '{8'h81, 8'h5a, 8'h01, 8'h80}; // Frame patterns.
  always #2.5 pclk = ~pclk;
  lso_core #(.POR_DELAY(PD), .DEGLITCH(DG)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sclk, .select_n, .mosi, .direct_drive_enable, .direct_drive_pull_en, .supply_good,
    .reset_n_out, .reset_n_oe, .mains_sense_in, .zero_cross_clock_out, .sink_outputs
  );
  lso_host host (.pclk, .sclk, .select_n, .mosi);
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits n cycles and stops where outputs are settled.
  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 8'h01, {7'h0, pready});
    rdata = prdata;
    rerr = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for the reset pin to release and checks how long that took.
  task automatic wait_rel;
    int n;
    n = 0;
    while (reset_n_oe !== 1'b0 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk("release", 8'h01, {7'h0, n >= PD && n <= PD + 8});
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence; the first frame starts only once the reset pin is released.
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    chk("sink_init", OUTREG_RESET, sink_outputs);
    wait_rel();
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("ctrl", CTRL_RESET[7:0], rdata[7:0]);
    chk("ok_resp", 8'h00, {7'h0, rerr});
    chk("rst_level", 8'h00, {7'h0, reset_n_out});
    foreach (pat[i]) begin
      host.send(pat[i], 8);
      cyc(10);
      chk("sink", pat[i], sink_outputs);
    end
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", 8'h80, rdata[7:0]);
    chk("status_hi", 8'h05, rdata[15:8]);
    host.send(8'h3c, 7);
    host.send(8'h3c, 9);
    cyc(10);
    chk("odd_count", 8'h80, sink_outputs);
    @(posedge pclk) direct_drive_enable <= 1'b1;
    cyc(6);
    chk("sink_output_one_or", 8'h81, sink_outputs);
    @(posedge pclk) direct_drive_enable <= 1'b0;
    cyc(6);
    chk("sink_output_one_reg", 8'h80, sink_outputs);
    apb(1'b1, CTRL_ADDR, 32'h0);
    host.send(8'h11, 8);
    cyc(10);
    chk("no_accept", 8'h80, sink_outputs);
    apb(1'b1, CTRL_ADDR, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped", 8'h01, {7'h0, rerr});
    @(posedge pclk) supply_good <= 1'b0;
    repeat (DG / 2) @(posedge pclk);
    supply_good <= 1'b1;
    cyc(8);
    chk("glitch", 8'h80, sink_outputs);
    @(posedge pclk) supply_good <= 1'b0;
    cyc(DG + 8);
    chk("low_supply", 8'h01, {7'h0, reset_n_oe});
    host.send(8'hff, 8);
    cyc(8);
    chk("held_off", 8'h00, sink_outputs);
    @(posedge pclk) supply_good <= 1'b1;
    wait_rel();
    chk("no_restore", 8'h00, sink_outputs);
    host.send(8'h24, 8);
    cyc(10);
    chk("rewrite", 8'h24, sink_outputs);
    @(posedge pclk) mains_sense_in <= 1'b1;
    cyc(200);
    chk("zc_pulse", 8'h00, {7'h0, zero_cross_clock_out});
    @(posedge pclk) mains_sense_in <= 1'b0;
    cyc(10);
    @(posedge pclk) mains_sense_in <= 1'b1;
    cyc(3950);
    chk("zc_wait", 8'h00, {7'h0, zero_cross_clock_out});
    cyc(100);
    chk("zc_follow", 8'h01, {7'h0, zero_cross_clock_out});
    @(posedge pclk) presetn <= 1'b0;
    cyc(2);
    chk("reset_clear", 8'h00, sink_outputs);
    @(posedge pclk) presetn <= 1'b1;
    wait_rel();
    chk("reset_stay", 8'h00, sink_outputs);
    final_report();
  end
  // Cuts a hang short well after the expected run of about 37 us.
  initial begin
    #200000;
    errors++;
    $display("BAD watchdog expected done seen hang");
    final_report();
  end
endmodule
`default_nettype wire
